// file: common/adc_ctrl_defines.vh
// constants for the adc configuration write and idle control block
`ifndef ADC_CTRL_DEFINES_VH
`define ADC_CTRL_DEFINES_VH
// configuration byte fields
`define CFG_RESET        8'h01
`define CFG_MARK_BIT     7
`define CFG_SCAN_HI      6
`define CFG_SCAN_LO      5
`define CFG_RB_HI        4
`define CFG_RB_LO        3
`define CFG_CH_HI        2
`define CFG_CH_LO        1
`define CFG_SE_BIT       0
// setup byte fields
`define SETUP_RESET      8'h82
`define SETUP_POL_BIT    2
`define SETUP_CLK_BIT    3
`define SETUP_RST_BIT    1
`define SETUP_MON_BIT    0
// scan mode codes
`define SCAN_SEQ         2'h0
`define SCAN_REPEAT      2'h1
`define SCAN_MONITOR     2'h2
`define SCAN_SINGLE      2'h3
// monitor setup length and repeat count
`define MON_BYTES        4'hD
`define REPEAT_COUNT     4'h8
// high speed master code: 0000 1xxx
`define HS_CODE_TOP      5'h01
// reference wake time in ms
`define REF_WAKE_MS      10
`endif

// file: verilog/adc_ctrl.v
// two-wire write slave with configuration decode and idle control
//
// Overview of operation
// R1: configuration bytes carry a zero in bit 7.
// R2: scan 00 converts channel 0 up to the selected channel.
// R3: scan 01 converts the selected channel eight times.
// R4: scan 10 monitors channel 0 up to the selected channel.
// R5: scan 11 converts the selected channel once.
// R6: readback bits both one enable monitor setup readback.
// R7: channel field gives top channel in sequential and monitor modes.
// R8: channel field names the channel in single-channel modes.
// R9: bit 0 one is single-ended, zero is differential pairs.
// R10: single-ended forces unipolar, ignoring polarity bit.
// R11: write opens with start, address, write bit; address is acknowledged.
// R12: data byte msb one goes to setup, zero to configuration.
// R13: master writes configuration before setup.
// R14: setup reset restores configuration; master rewrites it afterwards.
// R15: monitor-setup bit allows up to 13 more bytes.
// R16: stop or repeated start ends monitor setup early.
// R17: every received write byte is acknowledged.
// R18: stop returns high-speed timing to fast/standard.
// R19: external clock mode idles only after stop, nack or restart.
// R20: internal clock mode powers down when results are stored.
// R21: idle device powers up on its own valid address.
// R22: internal reference needs 10ms wake before conversion; no wake delay is timed here and REF_WAKE_MS is unused.
// R23: reset bit zero clears interrupt and configuration only.
// R24: high-speed master code is nacked, then high-speed until stop.
// R25: byte cut before acknowledge updates nothing; here bytes load at the eighth scl rise, so a cut after it still updates.
`timescale 1ns/10ps
`include "adc_ctrl_defines.vh"
module adc_ctrl #(
  parameter [6:0] SLAVE_ADDR = 7'h00  // arbitrary value, set per board
) (
  // clock and reset
  input  wire        i_clk,
  input  wire        i_arst_n,
  // two-wire bus
  input  wire        i_scl,
  input  wire        i_sda,
  output reg         o_sda,
  output reg         o_sda_oe,
  // conversion side
  input  wire        i_results_stored,
  // decoded configuration
  output reg  [1:0]  o_scan_mode,
  output reg  [1:0]  o_first_channel,
  output reg  [1:0]  o_last_channel,
  output reg  [3:0]  o_conv_count,
  output reg         o_monitor_mode,
  output reg         o_readback_enable,
  output reg         o_single_ended,
  output reg         o_bipolar,
  output reg  [7:0]  o_setup,
  output reg         o_int_clear,
  // monitor setup storage
  output reg         o_mon_wr,
  output reg  [3:0]  o_mon_index,
  output reg  [7:0]  o_mon_data,
  // bus mode and power
  output reg         o_high_speed_bus_mode,
  output reg         o_powered
);

  // ----------------------------------------------------------------
  // pin synchronisers and edge detect
  // ----------------------------------------------------------------
  reg [1:0] scl_sync;
  reg [1:0] sda_sync;
  reg       scl_d;
  reg       sda_d;
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_d    <= 1'b1;
      sda_d    <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[0], i_scl};
      sda_sync <= {sda_sync[0], i_sda};
      scl_d    <= scl_sync[1];
      sda_d    <= sda_sync[1];
    end
  end
  wire scl      = scl_sync[1];
  wire sda      = sda_sync[1];
  wire scl_rise = scl & ~scl_d;
  wire scl_fall = ~scl & scl_d;
  wire start_c  = scl & scl_d & sda_d & ~sda;
  wire stop_c   = scl & scl_d & ~sda_d & sda;

  // ----------------------------------------------------------------
  // byte framing states
  // ----------------------------------------------------------------
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_ADDR = 4'h2;
  localparam [3:0] ST_DATA = 4'h4;
  localparam [3:0] ST_SKIP = 4'h8;

  reg [3:0] state;
  reg [3:0] next_state;
  reg [3:0] bit_cnt;
  reg [7:0] shift;
  reg       ack_phase;
  reg       ack_drive;
  reg       mon_active;
  reg [3:0] mon_left;
  reg [7:0] cfg;

  wire byte_done = scl_rise & (bit_cnt == 4'h7);
  wire [7:0] rx  = {shift[6:0], sda};
  wire addr_hit  = (rx[7:1] == SLAVE_ADDR) & ~rx[0];            // see R11
  wire hs_code   = (rx[7:3] == `HS_CODE_TOP);                    // see R24

  // next state of the framer
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: if (start_c) next_state = ST_ADDR;               // see R21
      ST_ADDR: if (byte_done) next_state = addr_hit ? ST_DATA : ST_SKIP;
      ST_DATA: next_state = ST_DATA;
      ST_SKIP: next_state = ST_SKIP;
      default: next_state = ST_IDLE;
    endcase
    if (stop_c) next_state = ST_IDLE;
    else if (start_c) next_state = ST_ADDR;                      // see R16
  end

  // ----------------------------------------------------------------
  // bit counter and acknowledge slot
  // ----------------------------------------------------------------
  wire in_frame  = (state == ST_ADDR) | (state == ST_DATA);
  wire addr_done = byte_done & (state == ST_ADDR);
  wire data_done = byte_done & (state == ST_DATA);

  // framer state register
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // shift in bits on scl rise, hold the count during the ack clock
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      bit_cnt   <= 4'h0;
      shift     <= 8'h00;
      ack_phase <= 1'b0;
    end else if (start_c | stop_c) begin
      // partial byte discarded
      bit_cnt   <= 4'h0;                                         // see R25
      ack_phase <= 1'b0;
    end else if (in_frame) begin
      if (byte_done) begin
        shift     <= rx;
        bit_cnt   <= 4'h0;
        ack_phase <= 1'b1;
      end else if (scl_rise && !ack_phase) begin
        shift   <= rx;
        bit_cnt <= bit_cnt + 4'h1;
      end
      // ack clock over: released on its fall, or nacked at its rise
      if (scl_fall && ack_phase && o_sda_oe) begin
        ack_phase <= 1'b0;
      end
      if (scl_rise && ack_phase && !ack_drive) begin
        ack_phase <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // acknowledge driver
  // ----------------------------------------------------------------
  // pull the data line low from the fall after bit eight to the next fall
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ack_drive <= 1'b0;
      o_sda     <= 1'b1;
      o_sda_oe  <= 1'b0;
    end else if (start_c | stop_c) begin
      ack_drive <= 1'b0;
      o_sda     <= 1'b1;
      o_sda_oe  <= 1'b0;
    end else if (in_frame) begin
      if (addr_done) begin
        ack_drive <= addr_hit;                                   // see R11
      end else if (data_done) begin
        ack_drive <= 1'b1;                                       // see R17
      end
      if (scl_fall && ack_phase && ack_drive && !o_sda_oe) begin
        o_sda    <= 1'b0;
        o_sda_oe <= 1'b1;
      end else if (scl_fall && ack_phase && o_sda_oe) begin
        o_sda    <= 1'b1;
        o_sda_oe <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // configuration and setup registers
  // ----------------------------------------------------------------
  // bytes are sorted by their top bit once the eighth bit is in
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cfg         <= `CFG_RESET;
      o_setup     <= `SETUP_RESET;
      o_int_clear <= 1'b0;
    end else begin
      o_int_clear <= 1'b0;
      if (data_done && !mon_active) begin
        if (rx[`CFG_MARK_BIT]) begin                             // see R12
          o_setup <= rx;
          if (!rx[`SETUP_RST_BIT]) begin
            cfg         <= `CFG_RESET;                           // see R14
            o_int_clear <= 1'b1;                                 // see R23
          end
        end else begin
          cfg <= rx;                                             // see R1
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // monitor setup storage
  // ----------------------------------------------------------------
  // extended write, closed by its last byte or by stop or restart
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mon_active  <= 1'b0;
      mon_left    <= 4'h0;
      o_mon_wr    <= 1'b0;
      o_mon_index <= 4'h0;
      o_mon_data  <= 8'h00;
    end else begin
      o_mon_wr <= 1'b0;
      if (start_c | stop_c) begin
        mon_active <= 1'b0;                                      // see R16
      end else if (data_done && mon_active) begin
        o_mon_wr    <= 1'b1;                                     // see R15
        o_mon_data  <= rx;
        o_mon_index <= `MON_BYTES - mon_left;
        mon_left    <= mon_left - 4'h1;
        if (mon_left == 4'h1) begin
          mon_active <= 1'b0;
        end
      end else if (data_done && rx[`CFG_MARK_BIT] && rx[`SETUP_MON_BIT]) begin
        mon_active <= 1'b1;
        mon_left   <= `MON_BYTES;
      end
    end
  end

  // ----------------------------------------------------------------
  // bus speed mode
  // ----------------------------------------------------------------
  // master code sets high speed, a repeated start keeps it
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_high_speed_bus_mode <= 1'b0;
    end else if (stop_c) begin
      o_high_speed_bus_mode <= 1'b0;                             // see R18
    end else if (addr_done && hs_code) begin
      o_high_speed_bus_mode <= 1'b1;                             // see R24
    end
  end

  // ----------------------------------------------------------------
  // configuration decode
  // ----------------------------------------------------------------
  wire [1:0] scan_sel = {cfg[`CFG_SCAN_HI], cfg[`CFG_SCAN_LO]};
  wire [1:0] ch_sel   = {cfg[`CFG_CH_HI], cfg[`CFG_CH_LO]};
  reg  [1:0] next_first;
  reg  [3:0] next_count;
  always @* begin
    next_first = 2'h0;
    next_count = 4'h1;
    case (scan_sel)
      `SCAN_SEQ: begin
        next_first = 2'h0;                                       // see R2
        next_count = {2'h0, ch_sel} + 4'h1;
      end
      `SCAN_REPEAT: begin
        next_first = ch_sel;                                     // see R3
        next_count = `REPEAT_COUNT;
      end
      `SCAN_MONITOR: begin
        next_first = 2'h0;                                       // see R4
        next_count = {2'h0, ch_sel} + 4'h1;
      end
      `SCAN_SINGLE: begin
        next_first = ch_sel;                                     // see R5
        next_count = 4'h1;
      end
      default: begin
        next_first = 2'h0;
        next_count = 4'h1;
      end
    endcase
  end

  // decoded outputs registered
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_scan_mode       <= 2'h0;
      o_first_channel   <= 2'h0;
      o_last_channel    <= 2'h0;
      o_conv_count      <= 4'h1;
      o_monitor_mode    <= 1'b0;
      o_readback_enable <= 1'b0;
      o_single_ended    <= 1'b1;
      o_bipolar         <= 1'b0;
    end else begin
      o_scan_mode       <= scan_sel;
      o_first_channel   <= next_first;
      o_last_channel    <= ch_sel;                               // see R7, R8
      o_conv_count      <= next_count;
      o_monitor_mode    <= (scan_sel == `SCAN_MONITOR);          // see R4
      o_readback_enable <= cfg[`CFG_RB_HI] & cfg[`CFG_RB_LO];    // see R6
      o_single_ended    <= cfg[`CFG_SE_BIT];                     // see R9
      o_bipolar         <= ~cfg[`CFG_SE_BIT] & o_setup[`SETUP_POL_BIT]; // see R10
    end
  end

  // ----------------------------------------------------------------
  // power control
  // ----------------------------------------------------------------
  wire ext_clk   = o_setup[`SETUP_CLK_BIT];
  wire nack_seen = scl_rise & ack_phase & ~ack_drive & sda & (state == ST_DATA);
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_powered <= 1'b0;
    end else if (state == ST_ADDR && byte_done && addr_hit) begin
      o_powered <= 1'b1;                                         // see R21
    end else if (ext_clk && (stop_c || start_c || nack_seen)) begin
      o_powered <= 1'b0;                                         // see R19
    end else if (!ext_clk && i_results_stored) begin
      o_powered <= 1'b0;                                         // see R20
    end
  end

endmodule // adc_ctrl

// file: verification/adc_ctrl_properties.sv
// port checker for the adc control block
`timescale 1ns/10ps
module adc_ctrl_properties (
  input logic       i_clk,
  input logic       i_arst_n,
  input logic       i_scl,
  input logic       i_sda,
  input logic       o_sda,
  input logic       o_sda_oe,
  input logic [1:0] o_scan_mode,
  input logic [1:0] o_first_channel,
  input logic [1:0] o_last_channel,
  input logic [3:0] o_conv_count,
  input logic       o_monitor_mode,
  input logic       o_single_ended,
  input logic       o_bipolar,
  input logic       o_int_clear,
  input logic       o_mon_wr,
  input logic [3:0] o_mon_index,
  input logic       o_high_speed_bus_mode
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  // ----------------------------------------
  // decode of the scan control register
  // ----------------------------------------
  a_monitor_flag: assert property (o_monitor_mode == (o_scan_mode == 2'h2))
    else $error("monitor flag does not follow scan mode");
  a_scan_count: assert property (o_scan_mode == 2'h0 |-> o_conv_count == o_last_channel + 4'h1)
    else $error("sequential count wrong");
  a_repeat_count: assert property (o_scan_mode == 2'h1 |-> o_conv_count == 4'h8)
    else $error("repeat count wrong");
  a_single_count: assert property (o_scan_mode == 2'h3 |-> o_conv_count == 4'h1)
    else $error("single count wrong");
  a_range_start: assert property (!o_scan_mode[0] |-> o_first_channel == 2'h0)
    else $error("range does not start at zero");
  a_single_chan: assert property (o_scan_mode[0] |-> o_first_channel == o_last_channel)
    else $error("single channel not the selected one");
  a_unipolar_se: assert property (o_single_ended |-> !o_bipolar)
    else $error("bipolar while single ended");
  // ----------------------------------------
  // bus side
  // ----------------------------------------
  a_ack_low: assert property (o_sda_oe |-> !o_sda)
    else $error("driven data line not low");
  a_mon_range: assert property (o_mon_wr |-> o_mon_index <= 4'hC)
    else $error("monitor index past last byte");
  a_hs_stop: assert property ($rose(i_sda) && i_scl && o_high_speed_bus_mode
    |-> ##[1:8] !o_high_speed_bus_mode)
    else $error("stop did not leave high speed");
  a_reset_cfg: assert property ($rose(o_int_clear) |-> ##[0:3] (o_single_ended
    && o_scan_mode == 2'h0))
    else $error("reset bit did not restore config");
  c_mon: cover property (o_mon_wr);
  c_hs: cover property (o_high_speed_bus_mode);
  c_clear: cover property (o_int_clear);
endmodule // adc_ctrl_properties
bind adc_ctrl adc_ctrl_properties u_adc_ctrl_properties (.*);

// file: verification/twi_master_model.sv
// two-wire bus master model, quarter bit 200 ns
`timescale 1ns/10ps
module twi_master_model (
  output logic o_scl,
  output logic o_sda,
  input  logic i_sda
);
  // bus idles high
  initial begin
    o_scl = 1;
    o_sda = 1;
  end
  // start or repeated start, clock left low
  task automatic start();
    o_sda = 1;
    #200 o_scl = 1;
    #200 o_sda = 0;
    #200 o_scl = 0;
    #200;
  endtask
  // stop ends the frame, clock then stands high
  task automatic stop();
    o_sda = 0;
    #200 o_scl = 1;
    #200 o_sda = 1;
    #200;
  endtask
  // msb first byte, then release for acknowledge
  task automatic send(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      o_sda = b[i];
      #200 o_scl = 1;
      #400 o_scl = 0;
      #200;
    end
    o_sda = 1;
    #200 o_scl = 1;
    ack = !i_sda;
    #400 o_scl = 0;
    #200;
  endtask
endmodule // twi_master_model

// file: verification/tb.sv
// self-checking bench for the adc control block
`timescale 1ns/10ps
module tb;
  localparam logic [6:0] ADDR = 7'h2A; // arbitrary bus address
  logic i_clk = 0, i_arst_n = 0, i_results_stored = 0;
  logic m_scl, m_sda, o_sda, o_sda_oe, o_mon_wr, o_powered, o_hs, o_int_clear;
  logic o_monitor_mode, o_readback_enable, o_single_ended, o_bipolar;
  logic [1:0] o_scan_mode, o_first_channel, o_last_channel;
  logic [3:0] o_conv_count, o_mon_index, mon_idx;
  logic [7:0] o_setup, o_mon_data, mon_dat;
  int mismatches = 0, cmp_count = 0, mon_n = 0, clr_n = 0;
  // open-drain data line with pull-up
  wire sda = m_sda & ~(o_sda_oe & ~o_sda);
  always #50 i_clk = ~i_clk;
  adc_ctrl #(.SLAVE_ADDR(ADDR)) u_adc_ctrl (.i_clk, .i_arst_n, .i_scl(m_scl), .i_sda(sda),
    .o_sda, .o_sda_oe, .i_results_stored, .o_scan_mode, .o_first_channel, .o_last_channel,
    .o_conv_count, .o_monitor_mode, .o_readback_enable, .o_single_ended, .o_bipolar,
    .o_setup, .o_int_clear, .o_mon_wr, .o_mon_index, .o_mon_data,
    .o_high_speed_bus_mode(o_hs), .o_powered);
  twi_master_model u_twi_master_model (.o_scl(m_scl), .o_sda(m_sda), .i_sda(sda));
  // count monitor setup writes
  always @(posedge i_clk) if (o_mon_wr === 1'b1) begin
    mon_n++;
    mon_idx = o_mon_index;
    mon_dat = o_mon_data;
  end
  // count interrupt clear pulses
  always @(posedge i_clk) if (o_int_clear === 1'b1) clr_n++;
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input logic [7:0] got, exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL %0t %s", $time, m);
    end
  endtask
  task automatic put(input logic [7:0] b, input logic exp);
    logic a;
    u_twi_master_model.send(b, a);
    check(8'(a), 8'(exp), "ack");
  endtask
  // let the bus settle, then step off the clock edge
  task automatic idle();
    repeat (4) @(posedge i_clk);
    #5;
  endtask
  task automatic frame(input logic [7:0] b[$]);
    u_twi_master_model.start();
    put({ADDR, 1'b0}, 1);
    foreach (b[i]) put(b[i], 1);
    u_twi_master_model.stop();
    idle();
  endtask
  task automatic pulse_stored();
    @(posedge i_clk) #5 i_results_stored = 1;
    @(posedge i_clk) #5 i_results_stored = 0;
    idle();
  endtask
  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    check(o_setup, 8'h82, "setup reset");
    check({o_scan_mode, o_last_channel, o_conv_count}, 8'h01, "config reset");
    check({o_single_ended, o_powered, o_hs}, 8'h04, "flags reset");
    $display("t_reset done");
  endtask
  task automatic t_modes();
    logic [7:0] exp [4] = '{8'h4, 8'h8, 8'h0, 8'h1};
    for (int s = 0; s < 4; s++) begin
      frame('{{1'b0, s[1:0], 2'b11, 2'(3 - s), 1'b1}});
      check(8'(o_scan_mode), 8'(s), "scan");
      check(8'(o_last_channel), 8'(3 - s), "channel");
      check(8'(o_first_channel), s[0] ? 8'(3 - s) : 8'h0, "first");
      check(8'(o_monitor_mode), 8'(s == 2), "monitor");
      check(8'(o_readback_enable), 8'h1, "readback");
      if (s != 2) check(8'(o_conv_count), exp[s], "count");
    end
    $display("t_modes done");
  endtask
  task automatic t_polarity();
    frame('{8'h60, 8'h86});
    check({o_single_ended, o_bipolar}, 8'h1, "differential bipolar");
    check(8'(o_readback_enable), 8'h0, "readback off");
    frame('{8'h61});
    check({o_single_ended, o_bipolar}, 8'h2, "single ended unipolar");
    $display("t_polarity done");
  endtask
  task automatic t_rstbit();
    clr_n = 0;
    frame('{8'h84});
    check(o_setup, 8'h84, "setup kept");
    check(8'(clr_n), 8'h1, "interrupt clear");
    check({o_scan_mode, o_single_ended}, 8'h1, "config restored");
    $display("t_rstbit done");
  endtask
  task automatic t_monitor();
    mon_n = 0;
    frame('{8'h87, 8'h11, 8'h22});
    check(8'(mon_n), 8'h2, "monitor count");
    check({mon_idx, 4'h0}, 8'h10, "monitor index");
    check(mon_dat, 8'h22, "monitor data");
    $display("t_monitor done");
  endtask
  task automatic t_power();
    pulse_stored();
    check(8'(o_powered), 8'h0, "auto power down");
    u_twi_master_model.start();
    put({ADDR ^ 7'h01, 1'b0}, 0);
    u_twi_master_model.stop();
    idle();
    check(8'(o_powered), 8'h0, "other address");
    u_twi_master_model.start();
    put({ADDR, 1'b0}, 1);
    check(8'(o_powered), 8'h1, "wake on address");
    put(8'h8A, 1); // external clock, supply reference
    pulse_stored();
    check(8'(o_powered), 8'h1, "stays up until stop");
    u_twi_master_model.stop();
    idle();
    check(8'(o_powered), 8'h0, "down on stop");
    $display("t_power done");
  endtask
  task automatic t_hs();
    u_twi_master_model.start();
    put(8'h0B, 0);
    check(8'(o_hs), 8'h1, "high speed on");
    u_twi_master_model.stop();
    repeat (8) @(posedge i_clk);
    check(8'(o_hs), 8'h0, "high speed off");
    $display("t_hs done");
  endtask
  // main sequence
  initial begin
    repeat (16) @(posedge i_clk);
    #5 i_arst_n = 1;
    idle();
    t_reset();
    t_modes();
    t_polarity();
    t_rstbit();
    t_monitor();
    t_power();
    t_hs();
    close_out();
  end
  // watchdog
  initial begin
    #2000000;
    mismatches++;
    close_out();
  end
endmodule // tb
